// >>> inc/pmbus_fault_pkg.sv
`default_nettype none
package pmbus_fault_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_PAGE         = 8'h00;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL    = 8'h11;
  localparam logic [7:0] CMD_SUMMARY      = 8'h78;
  localparam logic [7:0] CMD_COMM_FAULT   = 8'h7e;
  localparam logic [7:0] CMD_MODEL        = 8'h9a;
  localparam logic [7:0] CMD_REVISION     = 8'h9b;
  localparam logic [7:0] CMD_DATE         = 8'h9d;
  localparam logic [7:0] CMD_SNAPSHOT     = 8'hd8;

  // ----------------------------------------------------------------
  // Page values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_A        = 8'h00;
  localparam logic [7:0] PAGE_B        = 8'h01;
  localparam logic [7:0] PAGE_ALL      = 8'hff;
  localparam int         SNAP_A_LSB    = 3;
  localparam int         SNAP_B_LSB    = 0;
  localparam int         CML_BAD_CMD   = 7;
  localparam int         CML_BAD_DATA  = 6;
  localparam logic [7:0] ID_BYTES      = 8'h02;

  // ----------------------------------------------------------------
  // Reset values (arbitrary identification defaults)
  // ----------------------------------------------------------------
  localparam logic [15:0] RESET_MODEL    = 16'h0001;
  localparam logic [15:0] RESET_REVISION = 16'h0001;
  localparam logic [15:0] RESET_DATE     = 16'h0101;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FC_NONE    = 3'h0,
    FC_OV_OFF  = 3'h1,
    FC_OV_ON   = 3'h2,
    FC_IIN_OC  = 3'h3,
    FC_IOUT_OC = 3'h4,
    FC_OT      = 3'h5,
    FC_STAGE   = 3'h6,
    FC_INPWR   = 3'h7
  } fault_code_t;

  typedef enum logic [2:0] {
    X_SEND        = 3'h0,
    X_WRITE_BYTE  = 3'h1,
    X_READ_BYTE   = 3'h2,
    X_WRITE_WORD  = 3'h3,
    X_READ_WORD   = 3'h4,
    X_BLOCK_WRITE = 3'h5,
    X_BLOCK_READ  = 3'h6
  } xact_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_STORE = 2'b10
  } nvm_fsm_t;

  typedef struct packed {
    logic        valid;
    xact_t       kind;
    logic [7:0]  code;
    logic [7:0]  count;
    logic [15:0] data;
  } pmbus_req_t;

  typedef struct packed {
    logic        valid;
    logic        ok;
    logic [7:0]  count;
    logic [15:0] data;
  } pmbus_rsp_t;

  typedef struct packed {
    logic ov;
    logic conv_on;
    logic iin_oc;
    logic iout_oc;
    logic ot;
    logic stage;
    logic inpwr;
  } fault_evt_t;

  typedef struct packed {
    logic vout_ov;
    logic iout_oc;
    logic vin_uv;
    logic temp;
    logic other;
  } status_evt_t;

  typedef struct packed {
    logic [7:0]  snapshot;
    logic [15:0] model;
    logic [15:0] revision;
    logic [15:0] date;
  } nvm_image_t;

endpackage
`default_nettype wire

// >>> rtl/channel_fault_record.sv
`timescale 1ns/1ps
`default_nettype none
module channel_fault_record (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  // Channel events
  input  wire pmbus_fault_pkg::fault_evt_t  fault_evt,
  input  wire pmbus_fault_pkg::status_evt_t status_evt,
  input  wire logic                         power_off,
  // Host controls
  input  wire logic                         clear_all,
  input  wire logic [7:0]                   cml_set,
  input  wire logic [7:0]                   cml_clr,
  input  wire logic                         code_clear,
  input  wire logic                         code_load,
  input  wire logic [2:0]                   code_load_value,
  // State
  output logic [2:0]                        code,
  output logic [7:0]                        summary,
  output logic [7:0]                        cml
);
  import pmbus_fault_pkg::*;

  typedef struct packed {
    logic [2:0] code;
    logic [7:0] cml;
    logic       cml_any;
    logic       vout_ov;
    logic       iout_oc;
    logic       vin_uv;
    logic       temp;
    logic       other;
    logic       off;
  } chan_state_t;

  chan_state_t s;
  chan_state_t next_s;
  fault_code_t new_code;

  // ----------------------------------------------------------------
  // Fault encoding
  // ----------------------------------------------------------------
  always_comb begin
    new_code = FC_NONE;
    if (fault_evt.ov) begin
      new_code = fault_evt.conv_on ? FC_OV_ON : FC_OV_OFF;
    end else if (fault_evt.iin_oc) begin
      new_code = FC_IIN_OC;
    end else if (fault_evt.iout_oc) begin
      new_code = FC_IOUT_OC;
    end else if (fault_evt.ot) begin
      new_code = FC_OT;
    end else if (fault_evt.stage) begin
      new_code = FC_STAGE;
    end else if (fault_evt.inpwr) begin
      new_code = FC_INPWR;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (code_load) begin
      next_s.code = code_load_value;
    end else if (code_clear) begin
      next_s.code = FC_NONE;
    end
    if (new_code != FC_NONE && !code_load && (s.code == FC_NONE || code_clear)) begin
      next_s.code = new_code;
    end
    next_s.vout_ov = (s.vout_ov & ~clear_all) | status_evt.vout_ov | fault_evt.ov;
    next_s.iout_oc = (s.iout_oc & ~clear_all) | status_evt.iout_oc | fault_evt.iout_oc;
    next_s.vin_uv  = (s.vin_uv & ~clear_all) | status_evt.vin_uv;
    next_s.temp    = (s.temp & ~clear_all) | status_evt.temp | fault_evt.ot;
    next_s.other   = (s.other & ~clear_all) | status_evt.other | fault_evt.iin_oc | fault_evt.stage
                     | fault_evt.inpwr;
    next_s.cml     = (s.cml & ~cml_clr & {8{~clear_all}}) | cml_set;
    next_s.cml_any = |next_s.cml;
    next_s.off     = power_off;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign code    = s.code;
  assign cml     = s.cml;
  assign summary = {1'b0, s.off, s.vout_ov, s.iout_oc, s.vin_uv, s.temp, s.cml_any, s.other};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_first_kept: assert property (
    ce && code != 3'h0 && !code_clear && !code_load |=> code == $past(code))
    else $error("first fault record overwritten");

  chk_ov_off_code: assert property (
    ce && code == 3'h0 && !code_load && fault_evt.ov && !fault_evt.conv_on |=> code == 3'h1)
    else $error("overvoltage while off not coded as one");

  chk_iout_code: assert property (
    ce && code == 3'h0 && !code_load && fault_evt == 7'b0001000 |=> code == 3'h4)
    else $error("output overcurrent not coded as four");

  chk_stage_code: assert property (
    ce && code == 3'h0 && !code_load && fault_evt == 7'b0000010 |=> code == 3'h6)
    else $error("power stage fault not coded as six");

  chk_flag_held: assert property (
    ce && summary[5] && !clear_all |=> summary[5])
    else $error("latched overvoltage flag dropped");

  chk_off_bit: assert property (
    ce && power_off |=> summary[6] && !summary[7])
    else $error("off bit or top bit wrong");

  chk_cml_summary: assert property (
    ce && cml_set != 8'h00 |=> summary[1] && (cml & $past(cml_set)) == $past(cml_set))
    else $error("comm fault set lost");

endmodule
`default_nettype wire

// >>> rtl/pmbus_fault_id_regs.sv
// How it works
// - Only the first catastrophic fault of a channel is captured in its record.
// - Channel A and B records live in separate instances, updated independently.
// - Snapshot register holds channel A code in bits 5:3, B in 2:0.
// - A record updates only while it is zero; later faults never overwrite.
// - Store command writes the record and identification words out to NVM.
// - Nonzero snapshot writes are dropped, flag comm fault and raise the alert.
// - Code 0 none, 1 overvoltage while off, 2 overvoltage while converting.
// - Code 3 input overcurrent, 4 output overcurrent, 5 overtemperature.
// - Code 6 power stage fault, 7 input overpower warning.
// - Model register holds 16 programmable NVM-backed bits, read back as written.
// - Revision register holds 16 programmable NVM-backed bits.
// - Date register holds 16 programmable NVM-backed bits.
// - Identification registers are served only by block write and block read.
// - Identification registers are shared, independent of the selected page.
// - Identification registers reset to built-in defaults until reprogrammed and committed.
// - Status flags latch until clear-faults; comm fault bits also clear on a host write of one.
// - Summary byte paged: 00h channel A, 01h channel B, FFh channel A.
// - Summary bit 7 reads zero, bit 6 set while output is off.
// - Writes to the summary byte are invalid transactions.
`timescale 1ns/1ps
`default_nettype none
module pmbus_fault_id_regs (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  // Host transactions
  input  wire pmbus_fault_pkg::pmbus_req_t  req,
  output pmbus_fault_pkg::pmbus_rsp_t       rsp,
  // Channel A events
  input  wire pmbus_fault_pkg::fault_evt_t  fault_evt_a,
  input  wire pmbus_fault_pkg::status_evt_t status_evt_a,
  input  wire logic                         power_off_a,
  // Channel B events
  input  wire pmbus_fault_pkg::fault_evt_t  fault_evt_b,
  input  wire pmbus_fault_pkg::status_evt_t status_evt_b,
  input  wire logic                         power_off_b,
  // NVM engine
  output logic                              nvm_store_req,
  output pmbus_fault_pkg::nvm_image_t       nvm_image,
  input  wire logic                         nvm_store_done,
  input  wire logic                         nvm_load_valid,
  input  wire pmbus_fault_pkg::nvm_image_t  nvm_load_image,
  // Alert
  output logic                              host_alert_pin
);
  import pmbus_fault_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  page;
    logic [15:0] model;
    logic [15:0] revision;
    logic [15:0] date;
    nvm_fsm_t    fsm;
    pmbus_rsp_t  rsp;
    logic        store_req;
    nvm_image_t  image;
    logic        alert;
  } main_state_t;

  localparam main_state_t RESET_S = '{
    page:      PAGE_A,
    model:     RESET_MODEL,
    revision:  RESET_REVISION,
    date:      RESET_DATE,
    fsm:       ST_IDLE,
    rsp:       '0,
    store_req: 1'b0,
    image:     '0,
    alert:     1'b0
  };

  main_state_t s;
  main_state_t next_s;

  logic [2:0]  code_a;
  logic [2:0]  code_b;
  logic [7:0]  sum_a;
  logic [7:0]  sum_b;
  logic [7:0]  cml_a;
  logic [7:0]  cml_b;
  logic [7:0]  snapshot;
  logic        idle;
  logic        take;
  logic        bad_cmd;
  logic        bad_data;
  logic        clear_all;
  logic        code_clear;
  logic        load;
  logic        sel_a;
  logic        sel_b;
  logic        read_b;
  logic [7:0]  w1c;
  logic [7:0]  err_set;
  logic [7:0]  cml_set_a;
  logic [7:0]  cml_set_b;
  logic [7:0]  cml_clr_a;
  logic [7:0]  cml_clr_b;

  // ----------------------------------------------------------------
  // Page steering and snapshot layout
  // ----------------------------------------------------------------
  assign idle     = (s.fsm == ST_IDLE);
  assign take     = req.valid && idle;
  assign load     = nvm_load_valid && idle;
  assign sel_a    = (s.page != PAGE_B);
  assign sel_b    = (s.page == PAGE_B) || (s.page == PAGE_ALL);
  assign read_b   = (s.page == PAGE_B);
  assign snapshot = (8'(code_a) << SNAP_A_LSB) | (8'(code_b) << SNAP_B_LSB);
  assign err_set  = (8'(bad_cmd) << CML_BAD_CMD) | (8'(bad_data) << CML_BAD_DATA);
  assign cml_set_a = sel_a ? err_set : 8'h00;
  assign cml_set_b = sel_b ? err_set : 8'h00;
  assign cml_clr_a = sel_a ? w1c : 8'h00;
  assign cml_clr_b = sel_b ? w1c : 8'h00;

  // ----------------------------------------------------------------
  // Per-channel records
  // ----------------------------------------------------------------
  channel_fault_record u_chan_a (
    .clk             (clk),
    .rst             (rst),
    .ce              (ce),
    .fault_evt       (fault_evt_a),
    .status_evt      (status_evt_a),
    .power_off       (power_off_a),
    .clear_all       (clear_all),
    .cml_set         (cml_set_a),
    .cml_clr         (cml_clr_a),
    .code_clear      (code_clear),
    .code_load       (load),
    .code_load_value (nvm_load_image.snapshot[SNAP_A_LSB +: 3]),
    .code            (code_a),
    .summary         (sum_a),
    .cml             (cml_a)
  );

  channel_fault_record u_chan_b (
    .clk             (clk),
    .rst             (rst),
    .ce              (ce),
    .fault_evt       (fault_evt_b),
    .status_evt      (status_evt_b),
    .power_off       (power_off_b),
    .clear_all       (clear_all),
    .cml_set         (cml_set_b),
    .cml_clr         (cml_clr_b),
    .code_clear      (code_clear),
    .code_load       (load),
    .code_load_value (nvm_load_image.snapshot[SNAP_B_LSB +: 3]),
    .code            (code_b),
    .summary         (sum_b),
    .cml             (cml_b)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    next_s           = s;
    next_s.rsp       = '0;
    next_s.store_req = 1'b0;
    bad_cmd          = 1'b0;
    bad_data         = 1'b0;
    clear_all        = 1'b0;
    code_clear       = 1'b0;
    w1c              = 8'h00;
    if (s.fsm == ST_STORE && nvm_store_done) begin
      next_s.fsm = ST_IDLE;
    end
    if (load) begin
      next_s.model    = nvm_load_image.model;
      next_s.revision = nvm_load_image.revision;
      next_s.date     = nvm_load_image.date;
    end
    if (req.valid) begin
      next_s.rsp.valid = 1'b1;
      next_s.rsp.ok    = idle;
    end
    if (take) begin
      case (req.code)
        CMD_PAGE: begin
          if (req.kind == X_WRITE_BYTE) begin
            if (req.data[7:0] == PAGE_A || req.data[7:0] == PAGE_B || req.data[7:0] == PAGE_ALL) begin
              next_s.page = req.data[7:0];
            end else begin
              bad_data = 1'b1;
            end
          end else if (req.kind == X_READ_BYTE) begin
            next_s.rsp.data  = {8'h00, s.page};
            next_s.rsp.count = 8'h01;
          end else begin
            bad_cmd = 1'b1;
          end
        end
        CMD_CLEAR_FAULTS: begin
          if (req.kind == X_SEND) begin
            clear_all = 1'b1;
          end else begin
            bad_cmd = 1'b1;
          end
        end
        CMD_STORE_ALL: begin
          if (req.kind == X_SEND) begin
            next_s.store_req      = 1'b1;
            next_s.image.snapshot = snapshot;
            next_s.image.model    = s.model;
            next_s.image.revision = s.revision;
            next_s.image.date     = s.date;
            next_s.fsm            = ST_STORE;
          end else begin
            bad_cmd = 1'b1;
          end
        end
        CMD_SUMMARY: begin
          if (req.kind == X_READ_BYTE) begin
            next_s.rsp.data  = {8'h00, read_b ? sum_b : sum_a};
            next_s.rsp.count = 8'h01;
          end else begin
            bad_cmd = 1'b1;
          end
        end
        CMD_COMM_FAULT: begin
          if (req.kind == X_READ_BYTE) begin
            next_s.rsp.data  = {8'h00, read_b ? cml_b : cml_a};
            next_s.rsp.count = 8'h01;
          end else if (req.kind == X_WRITE_BYTE) begin
            w1c = req.data[7:0];
          end else begin
            bad_cmd = 1'b1;
          end
        end
        CMD_MODEL, CMD_REVISION, CMD_DATE: begin
          if (req.kind == X_BLOCK_WRITE) begin
            if (req.count != ID_BYTES) begin
              bad_data = 1'b1;
            end else if (req.code == CMD_MODEL) begin
              next_s.model = req.data;
            end else if (req.code == CMD_REVISION) begin
              next_s.revision = req.data;
            end else begin
              next_s.date = req.data;
            end
          end else if (req.kind == X_BLOCK_READ) begin
            next_s.rsp.count = ID_BYTES;
            if (req.code == CMD_MODEL) begin
              next_s.rsp.data = s.model;
            end else if (req.code == CMD_REVISION) begin
              next_s.rsp.data = s.revision;
            end else begin
              next_s.rsp.data = s.date;
            end
          end else begin
            bad_cmd = 1'b1;
          end
        end
        CMD_SNAPSHOT: begin
          if (req.kind == X_WRITE_BYTE) begin
            if (req.data[7:0] == 8'h00) begin
              code_clear = 1'b1;
            end else begin
              bad_data = 1'b1;
            end
          end else if (req.kind == X_READ_BYTE) begin
            next_s.rsp.data  = {8'h00, snapshot};
            next_s.rsp.count = 8'h01;
          end else begin
            bad_cmd = 1'b1;
          end
        end
        default: begin
          bad_cmd = 1'b1;
        end
      endcase
    end
    if (bad_cmd || bad_data) begin
      next_s.rsp.ok    = 1'b0;
      next_s.rsp.data  = 16'h0000;
      next_s.rsp.count = 8'h00;
    end
    next_s.alert = (|sum_a[5:0]) | (|sum_b[5:0]);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= RESET_S;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign rsp            = s.rsp;
  assign nvm_store_req  = s.store_req;
  assign nvm_image      = s.image;
  assign host_alert_pin = s.alert;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_snap_reject: assert property (
    ce && take && req.code == CMD_SNAPSHOT && req.kind == X_WRITE_BYTE && req.data[7:0] != 8'h00
    |=> rsp.valid && !rsp.ok ##1 (host_alert_pin || !ce))
    else $error("nonzero snapshot write not rejected");

  chk_page_b_read: assert property (
    ce && take && req.code == CMD_SUMMARY && req.kind == X_READ_BYTE && s.page == PAGE_B
    |=> rsp.ok && rsp.data[7:0] == $past(sum_b))
    else $error("page one summary read wrong channel");

  chk_page_all_read: assert property (
    ce && take && req.code == CMD_SUMMARY && req.kind == X_READ_BYTE && s.page == PAGE_ALL
    |=> rsp.ok && rsp.data[7:0] == $past(sum_a))
    else $error("all pages summary read not channel A");

  chk_model_write: assert property (
    ce && take && !load && req.code == CMD_MODEL && req.kind == X_BLOCK_WRITE && req.count == ID_BYTES
    |=> s.model == $past(req.data) && rsp.ok)
    else $error("model block write not stored");

  chk_id_word_refused: assert property (
    ce && take && req.code == CMD_DATE && req.kind == X_WRITE_WORD
    |=> !rsp.ok && s.date == $past(s.date))
    else $error("word write to date accepted");

  chk_store_image: assert property (
    ce && take && req.code == CMD_STORE_ALL && req.kind == X_SEND
    |=> nvm_store_req && nvm_image.snapshot == $past(snapshot) && nvm_image.model == $past(s.model))
    else $error("store did not carry current record");

  chk_summary_write: assert property (
    ce && take && req.code == CMD_SUMMARY && req.kind == X_WRITE_BYTE |=> rsp.valid && !rsp.ok)
    else $error("summary write not treated as invalid");

endmodule
`default_nettype wire

// >>> verification/pmbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  // Bus
  input  wire logic                        clk,
  output var pmbus_fault_pkg::pmbus_req_t  req,
  input  wire pmbus_fault_pkg::pmbus_rsp_t rsp
);
  import pmbus_fault_pkg::*;
  initial req = '0;
  // One transfer, answer taken an edge later
  task automatic xfer(input xact_t k, input logic [7:0] c, input logic [15:0] d, output pmbus_rsp_t r);
    @(posedge clk);
    req <= '{1'b1, k, c, ID_BYTES, d};
    @(posedge clk);
    req <= '0;
    #1 r = rsp;
  endtask
endmodule
`default_nettype wire

// >>> verification/pmbus_fault_id_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pmbus_fault_id_regs_bench;
  import pmbus_fault_pkg::*;
  localparam logic [6:0] EV [1:7] = '{7'h40, 7'h60, 7'h10, 7'h08, 7'h04, 7'h02, 7'h01};
  logic       clk, rst, power_off_a, power_off_b, nvm_store_req, nvm_store_done, host_alert_pin;
  logic       nvm_load_valid;
  nvm_image_t nvm_load_image;
  pmbus_req_t req;
  pmbus_rsp_t rsp, r;
  fault_evt_t fault_evt_a, fault_evt_b;
  nvm_image_t nvm_image;
  int         n_mismatch, compares;

  pmbus_host_model host (.clk(clk), .req(req), .rsp(rsp));
  pmbus_fault_id_regs dut (.clk(clk), .rst(rst), .ce(1'b1), .req(req), .rsp(rsp),
    .fault_evt_a(fault_evt_a), .status_evt_a('0), .power_off_a(power_off_a),
    .fault_evt_b(fault_evt_b), .status_evt_b('0), .power_off_b(power_off_b),
    .nvm_store_req(nvm_store_req), .nvm_image(nvm_image), .nvm_store_done(nvm_store_done),
    .nvm_load_valid(nvm_load_valid), .nvm_load_image(nvm_load_image), .host_alert_pin(host_alert_pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Storage engine finishes one cycle after the request
  always @(posedge clk) nvm_store_done <= nvm_store_req;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input xact_t k, input logic [7:0] c, input logic [15:0] exp);
    host.xfer(k, c, 16'h0000, r);
    chk({r.valid, r.ok}, 16'h0003);
    chk(r.data, exp);
    chk(r.count, (k == X_BLOCK_READ) ? 16'h0002 : 16'h0001);
  endtask
  task automatic wr(input xact_t k, input logic [7:0] c, input logic [15:0] d, input logic ok);
    host.xfer(k, c, d, r);
    chk({r.valid, r.ok}, {1'b1, ok});
  endtask
  task automatic pulse(input fault_evt_t a, input fault_evt_t b);
    @(posedge clk);
    fault_evt_a <= a;
    fault_evt_b <= b;
    @(posedge clk);
    fault_evt_a <= '0;
    fault_evt_b <= '0;
  endtask
  task automatic finish_test;
    $display("Compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic t_reset;
    rd(X_BLOCK_READ, CMD_MODEL, RESET_MODEL);
    rd(X_BLOCK_READ, CMD_REVISION, RESET_REVISION);
    rd(X_BLOCK_READ, CMD_DATE, RESET_DATE);
    rd(X_READ_BYTE, CMD_SUMMARY, 16'h0000);
  endtask
  task automatic t_ids;
    logic [7:0] cd [3] = '{CMD_MODEL, CMD_REVISION, CMD_DATE};
    wr(X_WRITE_BYTE, CMD_PAGE, 16'h0001, 1'b1);
    foreach (cd[i]) wr(X_BLOCK_WRITE, cd[i], 16'hc3a5 + 16'(i), 1'b1);
    wr(X_WRITE_BYTE, CMD_PAGE, 16'h00ff, 1'b1);
    foreach (cd[i]) rd(X_BLOCK_READ, cd[i], 16'hc3a5 + 16'(i));
    wr(X_WRITE_WORD, CMD_MODEL, 16'h1234, 1'b0);
    rd(X_BLOCK_READ, CMD_MODEL, 16'hc3a5);
  endtask
  task automatic t_codes;
    for (int c = 1; c < 8; c++) begin
      wr(X_WRITE_BYTE, CMD_SNAPSHOT, 16'h0000, 1'b1);
      pulse(EV[c], EV[8 - c]);
      pulse(EV[8 - c], EV[c]);
      rd(X_READ_BYTE, CMD_SNAPSHOT, {10'h000, 3'(c), 3'(8 - c)});
    end
  endtask
  task automatic t_status;
    wr(X_SEND, CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
    wr(X_WRITE_BYTE, CMD_PAGE, 16'h0000, 1'b1);
    @(posedge clk);
    power_off_a <= 1'b1;
    wr(X_WRITE_BYTE, CMD_SNAPSHOT, 16'h0005, 1'b0);
    @(posedge clk);
    #1 chk(host_alert_pin, 16'h0001);
    rd(X_READ_BYTE, CMD_SNAPSHOT, 16'h0039);
    rd(X_READ_BYTE, CMD_SUMMARY, 16'h0042);
    wr(X_WRITE_BYTE, CMD_SUMMARY, 16'h0000, 1'b0);
    wr(X_SEND, CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
    rd(X_READ_BYTE, CMD_SUMMARY, 16'h0040);
    wr(X_WRITE_BYTE, CMD_PAGE, 16'h0001, 1'b1);
    rd(X_READ_BYTE, CMD_SUMMARY, 16'h0000);
    wr(X_WRITE_BYTE, CMD_PAGE, 16'h00ff, 1'b1);
    rd(X_READ_BYTE, CMD_SUMMARY, 16'h0040);
  endtask
  task automatic t_store(input logic [7:0] snap);
    wr(X_SEND, CMD_STORE_ALL, 16'h0000, 1'b1);
    chk(nvm_store_req, 16'h0001);
    chk(nvm_image.snapshot, snap);
    chk(nvm_image.model, 16'hc3a5);
    repeat (3) @(posedge clk);
  endtask
  task automatic t_load;
    @(posedge clk);
    nvm_load_image <= '{8'h0a, 16'h5a5a, 16'h0202, 16'h0303};
    nvm_load_valid <= 1'b1;
    @(posedge clk);
    nvm_load_valid <= 1'b0;
    rd(X_BLOCK_READ, CMD_MODEL, 16'h5a5a);
    rd(X_BLOCK_READ, CMD_DATE, 16'h0303);
    rd(X_READ_BYTE, CMD_SNAPSHOT, 16'h000a);
  endtask

  initial begin
    {rst, power_off_a, power_off_b, nvm_load_valid} = 4'b1000;
    nvm_load_image = '0;
    fault_evt_a = '0;
    fault_evt_b = '0;
    n_mismatch = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ids();
    t_codes();
    t_status();
    t_store(8'h39);
    wr(X_WRITE_BYTE, CMD_SNAPSHOT, 16'h0000, 1'b1);
    t_store(8'h00);
    t_load();
    finish_test();
  end
endmodule
`default_nettype wire
